/* File: core/fpc_regs.svh */
// Purpose: constants of the parallel configuration port
// Assumes: MCLK at 20 MHz, counts derived from printed times
// Notes: long counts except power-on are top-level parameters built from these
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_MCLK_MHZ 20
`define FPC_NS_PER_US 1000
`define FPC_POR_US 100
`define FPC_POR_CYC (`FPC_POR_US * `FPC_MCLK_MHZ)
`define FPC_CF2ST0_NS 600
`define FPC_CF2ST0_CYC ((`FPC_CF2ST0_NS * `FPC_MCLK_MHZ) / `FPC_NS_PER_US)
`define FPC_STATUS_MIN_US 268
`define FPC_STATUS_MAX_US 1506
`define FPC_UM_MIN_US 175
`define FPC_UM_MAX_US 437
`define FPC_CLK_MAX_PERIOD_NS 10
`define FPC_CD2CU_NS (4 * `FPC_CLK_MAX_PERIOD_NS)
`define FPC_CD2CU_CYC \
  ((`FPC_CD2CU_NS * `FPC_MCLK_MHZ + `FPC_NS_PER_US - 1) / `FPC_NS_PER_US)
`define FPC_USER_EDGES 8576
`define FPC_RATIO_1 4'h1
`define FPC_RATIO_2 4'h2
`define FPC_RATIO_4 4'h4
`define FPC_RATIO_8 4'h8
`endif

/* File: core/fpc_pkg.sv */
// Purpose: types and shared decoding of the configuration port
// Assumes: width codes as listed in fpc_width_t
// Notes: ratio decoded on MCLK, data mask applied on the configuration clock
`include "fpc_regs.svh"
package fpc_pkg;
  typedef enum logic [1:0] {
    W8 = 2'h0, W16 = 2'h1, W32 = 2'h2
  } fpc_width_t;
  typedef enum logic [2:0] {
    S_POR = 3'h0, S_STATUS = 3'h1, S_LOAD = 3'h3,
    S_INIT = 3'h2, S_USER = 3'h6, S_CLEAR = 3'h7
  } fpc_state_t;

  function automatic logic [3:0] ratio(input logic [1:0] w,
                                       input logic dec, input logic sec);
    logic [3:0] r;
    r = `FPC_RATIO_1;
    if (w == W8) begin
      r = dec ? `FPC_RATIO_2 : `FPC_RATIO_1;
    end else if (w == W16) begin
      r = dec ? `FPC_RATIO_4 : (sec ? `FPC_RATIO_2 : `FPC_RATIO_1);
    end else begin
      r = dec ? `FPC_RATIO_8 : (sec ? `FPC_RATIO_4 : `FPC_RATIO_1);
    end
    return r;
  endfunction

  function automatic logic [31:0] mask(input logic [1:0] w,
                                       input logic [31:0] d);
    logic [31:0] m;
    m = d;
    if (w == W8) begin
      m = {24'h0, d[7:0]};
    end else if (w == W16) begin
      m = {16'h0, d[15:0]};
    end
    return m;
  endfunction
endpackage

/* File: core/fpc_sync.sv */
// Purpose: two-flop level synchroniser
// Assumes: input is a level from another domain
// Notes: first flop read only by the second
`timescale 1ns/1ps
module fpc_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // fpc_sync

/* File: core/fpc_link.sv */
// Purpose: word capture and processing on the configuration clock
// Assumes: ratio, width and image size steady while arst_n is high
// Notes: arst_n comes from an MCLK flop; clock is idle at release
`timescale 1ns/1ps
`include "fpc_regs.svh"
module fpc_link (
  input wire logic cfg_clk,
  input wire logic arst_n,
  input wire logic [3:0] ratio,
  input wire logic [1:0] width,
  input wire logic [31:0] image_words,
  input wire logic [31:0] data,
  output logic done_q,
  output logic init_go_q,
  output logic [31:0] sum_q
);
  logic [2:0] phase_q;
  logic [31:0] cnt_q;
  logic [31:0] word_q;
  logic [31:0] cnt_n;
  logic [31:0] din;
  logic [1:0] fall_q;
  logic wrap;
  logic take;

  assign take = (phase_q == 3'h0);
  assign wrap = ({1'b0, phase_q} == ratio - 4'h1);
  assign cnt_n = cnt_q + {31'h0, take};
  assign din = fpc_pkg::mask(width, data);

  always_ff @(posedge cfg_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 3'h0;
      cnt_q <= 32'h0;
      word_q <= 32'h0;
    end else if (!done_q) begin
      phase_q <= wrap ? 3'h0 : phase_q + 3'h1;
      cnt_q <= cnt_n;
      if (take) begin
        word_q <= din;
      end
    end
  end

  // spare cycles fold word into result; at ratio 1 every cycle folds the input
  always_ff @(posedge cfg_clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_q <= 32'h0;
    end else if (!done_q) begin
      if (ratio == `FPC_RATIO_1) begin
        sum_q <= {sum_q[30:0], sum_q[31]} ^ din;
      end else if (!take) begin
        sum_q <= {sum_q[30:0], sum_q[31]} ^ word_q;
      end
    end
  end

  // done only after ratio-1 spare cycles
  always_ff @(posedge cfg_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (wrap && cnt_n == image_words) begin
      done_q <= 1'b1;
    end
  end

  always_ff @(negedge cfg_clk or negedge arst_n) begin
    if (!arst_n) begin
      fall_q <= 2'h0;
      init_go_q <= 1'b0;
    end else if (done_q && !init_go_q) begin
      fall_q <= fall_q + 2'h1;
      init_go_q <= (fall_q == 2'h1);
    end
  end
endmodule // fpc_link

/* File: core/fpc_top.sv */
// Purpose: passive parallel configuration port, device side
// Assumes: pins and user clock are asynchronous to MCLK
// Notes: option inputs are sampled during power-on and while request is low, except INIT_DONE_OPT, taken when the image completes
`timescale 1ns/1ps
`include "fpc_regs.svh"
module fpc_top #(
  parameter int STATUS_CYC = `FPC_STATUS_MIN_US * `FPC_MCLK_MHZ,
  parameter int STATUS_MAX_CYC = `FPC_STATUS_MAX_US * `FPC_MCLK_MHZ,
  parameter int UM_MIN_CYC = `FPC_UM_MIN_US * `FPC_MCLK_MHZ,
  parameter int USER_EDGES = `FPC_USER_EDGES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CONFIG_CLOCK,
  input wire logic CONFIG_REQ_N,
  input wire logic [31:0] DATA,
  input wire logic [1:0] WIDTH_SEL,
  input wire logic DECOMP_EN,
  input wire logic SECURITY_EN,
  input wire logic USER_INIT_CLOCK_EN,
  input wire logic USER_INIT_CLOCK,
  input wire logic INIT_DONE_OPT,
  input wire logic [31:0] IMAGE_WORDS,
  output logic STATUS_N,
  output logic CONF_DONE,
  output logic INIT_DONE,
  output logic INIT_DONE_OE,
  output logic USER_MODE,
  output logic [3:0] RATIO,
  output logic [31:0] RESULT
);
  localparam int R13_MAX = `FPC_CF2ST0_CYC - 3;
  localparam int POR_CYC = `FPC_POR_CYC;
  localparam int CU_CYC = `FPC_CD2CU_CYC;

  fpc_pkg::fpc_state_t state_q;
  fpc_pkg::fpc_state_t state_d;
  logic req_n_s;
  logic [1:0] width_s;
  logic dec_s;
  logic sec_s;
  logic uopt_s;
  logic idopt_s;
  logic uclk_s;
  logic uclk_q;
  logic done_s;
  logic go_s;
  logic done_l;
  logic go_l;
  logic [31:0] sum_l;
  logic [1:0] width_q;
  logic dec_q;
  logic sec_q;
  logic uopt_q;
  logic [31:0] words_q;
  logic [31:0] words_m_q;
  logic [31:0] words_s_q;
  logic arm_q;
  logic link_rst_n;
  logic [31:0] cnt_q;
  logic [13:0] edges_q;
  logic cu_ok_q;
  logic idopt_q;
  logic timer_done;

  fpc_sync u_sreq (.clk(MCLK), .rst_n(RST_N), .d(CONFIG_REQ_N),
    .q(req_n_s));
  fpc_sync u_sw0 (.clk(MCLK), .rst_n(RST_N), .d(WIDTH_SEL[0]),
    .q(width_s[0]));
  fpc_sync u_sw1 (.clk(MCLK), .rst_n(RST_N), .d(WIDTH_SEL[1]),
    .q(width_s[1]));
  fpc_sync u_sdec (.clk(MCLK), .rst_n(RST_N), .d(DECOMP_EN), .q(dec_s));
  fpc_sync u_ssec (.clk(MCLK), .rst_n(RST_N), .d(SECURITY_EN), .q(sec_s));
  fpc_sync u_suo (.clk(MCLK), .rst_n(RST_N), .d(USER_INIT_CLOCK_EN),
    .q(uopt_s));
  fpc_sync u_sid (.clk(MCLK), .rst_n(RST_N), .d(INIT_DONE_OPT),
    .q(idopt_s));
  fpc_sync u_suc (.clk(MCLK), .rst_n(RST_N), .d(USER_INIT_CLOCK),
    .q(uclk_s));
  fpc_sync u_sdone (.clk(MCLK), .rst_n(RST_N), .d(done_l), .q(done_s));
  fpc_sync u_sgo (.clk(MCLK), .rst_n(RST_N), .d(go_l), .q(go_s));

  // Link logic held clear outside load and init
  assign link_rst_n = RST_N & arm_q;

  fpc_link u_link (
    .cfg_clk(CONFIG_CLOCK),
    .arst_n(link_rst_n),
    .ratio(RATIO),
    .width(width_q),
    .image_words(words_q),
    .data(DATA),
    .done_q(done_l),
    .init_go_q(go_l),
    .sum_q(sum_l)
  );

  assign timer_done = uopt_q ? (cu_ok_q && edges_q == 14'(USER_EDGES))
                             : (cnt_q >= 32'(UM_MIN_CYC));

  // State sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      fpc_pkg::S_POR: begin
        if (cnt_q >= 32'(POR_CYC - 1)) begin
          state_d = fpc_pkg::S_STATUS;
        end
      end
      fpc_pkg::S_CLEAR: begin
        if (req_n_s) begin
          state_d = fpc_pkg::S_STATUS;
        end
      end
      fpc_pkg::S_STATUS: begin
        if (cnt_q >= 32'(STATUS_CYC - 1)) begin
          state_d = fpc_pkg::S_LOAD;
        end
      end
      fpc_pkg::S_LOAD: begin
        if (done_s) begin
          state_d = fpc_pkg::S_INIT;
        end
      end
      fpc_pkg::S_INIT: begin
        if (go_s && timer_done) begin
          state_d = fpc_pkg::S_USER;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
    // request low restarts from any state except power-on
    if (!req_n_s && state_q != fpc_pkg::S_POR) begin
      state_d = fpc_pkg::S_CLEAR;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= fpc_pkg::S_POR;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 32'h0;
    end else if (state_d != state_q) begin
      cnt_q <= 32'h0;
    end else if (cnt_q != 32'hffffffff) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // Options frozen outside power-on and clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      width_q <= 2'h0;
      dec_q <= 1'b0;
      sec_q <= 1'b0;
      uopt_q <= 1'b0;
      words_q <= 32'h0;
      RATIO <= `FPC_RATIO_1;
    end else if (state_q == fpc_pkg::S_CLEAR ||
                 state_q == fpc_pkg::S_POR) begin
      width_q <= width_s;
      dec_q <= dec_s;
      sec_q <= sec_s;
      uopt_q <= uopt_s;
      words_q <= words_s_q;
      RATIO <= fpc_pkg::ratio(width_s, dec_s, sec_s);
    end
  end

  // Image size pin through two flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      words_m_q <= 32'h0;
      words_s_q <= 32'h0;
    end else begin
      words_m_q <= IMAGE_WORDS;
      words_s_q <= words_m_q;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      arm_q <= 1'b0;
    end else begin
      arm_q <= (state_d == fpc_pkg::S_LOAD || state_d == fpc_pkg::S_INIT);
    end
  end

  // user clock edges after enable delay
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      uclk_q <= 1'b0;
      edges_q <= 14'h0;
      cu_ok_q <= 1'b0;
    end else begin
      uclk_q <= uclk_s;
      if (state_q != fpc_pkg::S_INIT) begin
        edges_q <= 14'h0;
        cu_ok_q <= 1'b0;
      end else begin
        cu_ok_q <= cu_ok_q | (cnt_q >= 32'(CU_CYC - 1));
        if (cu_ok_q && uclk_s && !uclk_q &&
            edges_q != 14'(USER_EDGES)) begin
          edges_q <= edges_q + 14'h1;
        end
      end
    end
  end

  // Pin drive and result capture
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      STATUS_N <= 1'b0;
      CONF_DONE <= 1'b0;
      USER_MODE <= 1'b0;
      RESULT <= 32'h0;
      idopt_q <= 1'b0;
    end else begin
      // status low in power-on and pulse
      STATUS_N <= !(state_d == fpc_pkg::S_POR ||
                    state_d == fpc_pkg::S_CLEAR ||
                    state_d == fpc_pkg::S_STATUS);
      // done high only after full image
      CONF_DONE <= (state_d == fpc_pkg::S_INIT ||
                    state_d == fpc_pkg::S_USER);
      USER_MODE <= (state_d == fpc_pkg::S_USER);
      if (state_q == fpc_pkg::S_LOAD && done_s) begin
        RESULT <= sum_l;
        idopt_q <= idopt_s;
      end else if (state_q == fpc_pkg::S_CLEAR) begin
        idopt_q <= 1'b0;
      end
    end
  end

  assign INIT_DONE_OE = idopt_q;
  assign INIT_DONE = idopt_q & USER_MODE;

  property p_req_low;
    @(posedge MCLK) disable iff (!RST_N)
    $fell(req_n_s) && state_q != fpc_pkg::S_POR
      |-> ##[1:R13_MAX] (!STATUS_N && !CONF_DONE);
  endproperty
  a_req_low: assert property (p_req_low)
    else $error("status or done not low after request");

  property p_status_min;
    @(posedge MCLK) disable iff (!RST_N)
    $rose(STATUS_N) && $past(state_q) == fpc_pkg::S_STATUS
      |-> $past(cnt_q) >= 32'(STATUS_CYC - 1);
  endproperty
  a_status_min: assert property (p_status_min)
    else $error("status pulse too short");

  property p_status_max;
    @(posedge MCLK) disable iff (!RST_N)
    state_q == fpc_pkg::S_STATUS |-> cnt_q < 32'(STATUS_MAX_CYC);
  endproperty
  a_status_max: assert property (p_status_max)
    else $error("status pulse too long");

  property p_done_low;
    @(posedge MCLK) disable iff (!RST_N)
    state_q inside {fpc_pkg::S_POR, fpc_pkg::S_STATUS,
                    fpc_pkg::S_LOAD, fpc_pkg::S_CLEAR}
      |=> $past(state_d) == fpc_pkg::S_INIT || !CONF_DONE;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done high before image complete");

  property p_user_lines;
    @(posedge MCLK) disable iff (!RST_N)
    USER_MODE |-> STATUS_N && CONF_DONE;
  endproperty
  a_user_lines: assert property (p_user_lines)
    else $error("user mode with a line low");

  property p_por_low;
    @(posedge MCLK) disable iff (!RST_N)
    state_q == fpc_pkg::S_POR |-> !STATUS_N;
  endproperty
  a_por_low: assert property (p_por_low)
    else $error("status high during power-on delay");

  property p_osc_init;
    @(posedge MCLK) disable iff (!RST_N)
    $rose(USER_MODE) && !uopt_q |-> $past(cnt_q) >= 32'(UM_MIN_CYC);
  endproperty
  a_osc_init: assert property (p_osc_init)
    else $error("user mode too early");

  property p_uclk_init;
    @(posedge MCLK) disable iff (!RST_N)
    $rose(USER_MODE) && uopt_q |-> $past(edges_q) == 14'(USER_EDGES);
  endproperty
  a_uclk_init: assert property (p_uclk_init)
    else $error("user mode before user clock count");

  property p_init_low;
    @(posedge MCLK) disable iff (!RST_N)
    INIT_DONE_OE && !USER_MODE |-> !INIT_DONE;
  endproperty
  a_init_low: assert property (p_init_low)
    else $error("init-complete high before user mode");

  property p_done_cause;
    @(posedge MCLK) disable iff (!RST_N)
    $rose(CONF_DONE) |-> $past(done_s);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done rose without full image");

  property p_ratio32;
    @(posedge MCLK) disable iff (!RST_N)
    width_q == fpc_pkg::W32 && dec_q && state_q == fpc_pkg::S_LOAD
      |-> RATIO == `FPC_RATIO_8;
  endproperty
  a_ratio32: assert property (p_ratio32)
    else $error("wrong ratio for compressed wide mode");

  c_user: cover property (@(posedge MCLK) $rose(USER_MODE));
  c_reconf: cover property (@(posedge MCLK)
    USER_MODE ##1 state_q == fpc_pkg::S_CLEAR);
  c_uclk: cover property (@(posedge MCLK) $rose(USER_MODE) && uopt_q);
endmodule // fpc_top

/* File: test/fpc_host.sv */
// Purpose: behavioural configuration host for the parallel port
// Assumes: link clock period 64 ns, parked low outside frames
// Notes: data shows the inverse of the last word once released
`timescale 1ns/1ps
module fpc_host (
  output logic cfg_clk,
  output logic req_n,
  output logic [31:0] data,
  input wire logic status_n
);
  localparam int HALF = 32;

  initial begin
    cfg_clk = 1'b0;
    req_n = 1'b1;
    data = 32'h0;
  end

  function automatic logic [31:0] word(input int i);
    return {8'(i), 8'h5a, 8'(8'hc3 ^ 8'(i)), 8'(i + 1)};
  endfunction

  task automatic request(input int ns);
    req_n <= 1'b0;
    #(ns);
    req_n <= 1'b1;
  endtask

  task automatic load(input int first, input int cnt, input int r,
                      input int pause_at);
    if (first == 0) begin
      wait (status_n === 1'b1);
      #2000;
    end
    for (int i = first; i < first + cnt; i++) begin
      if (i == pause_at) begin
        data = ~data;
        #1000;
      end
      data = word(i);
      #(HALF);
      for (int k = 0; k < r; k++) begin
        cfg_clk = 1'b1;
        #(HALF);
        cfg_clk = 1'b0;
        #(HALF);
      end
    end
    data = ~data;
  endtask

  task automatic tail();
    for (int k = 0; k < 2; k++) begin
      #(HALF);
      cfg_clk = 1'b1;
      #(HALF);
      cfg_clk = 1'b0;
    end
  endtask
endmodule // fpc_host

/* File: test/testbench.sv */
// Purpose: self-checking bench for the parallel configuration port
// Assumes: shortened status, init and user clock counts
// Notes: host model drives the link side
`timescale 1ns/1ps
module testbench;
  localparam int ST = 20;
  localparam int STMAX = 40;
  localparam int UM = 10;
  localparam int UE = 4;
  localparam int LIMIT = 9000;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic CONFIG_CLOCK;
  logic CONFIG_REQ_N;
  logic [31:0] DATA;
  logic [1:0] WIDTH_SEL = 2'h0;
  logic DECOMP_EN = 1'b0;
  logic SECURITY_EN = 1'b0;
  logic USER_INIT_CLOCK_EN = 1'b0;
  logic USER_INIT_CLOCK = 1'b0;
  logic INIT_DONE_OPT = 1'b0;
  logic [31:0] IMAGE_WORDS = 32'h1;
  logic STATUS_N;
  logic CONF_DONE;
  logic INIT_DONE;
  logic INIT_DONE_OE;
  logic USER_MODE;
  logic [3:0] RATIO;
  logic [31:0] RESULT;
  logic [1:0] udiv = 2'h0;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;

  fpc_top #(.STATUS_CYC(ST), .STATUS_MAX_CYC(STMAX), .UM_MIN_CYC(UM),
    .USER_EDGES(UE)) DUT (.MCLK(MCLK), .RST_N(RST_N),
    .CONFIG_CLOCK(CONFIG_CLOCK), .CONFIG_REQ_N(CONFIG_REQ_N), .DATA(DATA),
    .WIDTH_SEL(WIDTH_SEL), .DECOMP_EN(DECOMP_EN),
    .SECURITY_EN(SECURITY_EN), .USER_INIT_CLOCK_EN(USER_INIT_CLOCK_EN),
    .USER_INIT_CLOCK(USER_INIT_CLOCK), .INIT_DONE_OPT(INIT_DONE_OPT),
    .IMAGE_WORDS(IMAGE_WORDS), .STATUS_N(STATUS_N), .CONF_DONE(CONF_DONE),
    .INIT_DONE(INIT_DONE), .INIT_DONE_OE(INIT_DONE_OE),
    .USER_MODE(USER_MODE), .RATIO(RATIO), .RESULT(RESULT));

  fpc_host host (.cfg_clk(CONFIG_CLOCK), .req_n(CONFIG_REQ_N), .data(DATA),
    .status_n(STATUS_N));

  always #25 MCLK = ~MCLK;

  // User clock at one eighth of MCLK
  always @(posedge MCLK) begin
    udiv <= udiv + 2'h1;
    if (udiv == 2'h3) begin
      USER_INIT_CLOCK <= ~USER_INIT_CLOCK;
    end
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic check_bit(input string name, input logic exp,
                           input logic got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_nib(input string name, input logic [3:0] exp,
                           input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_word(input string name, input logic [31:0] exp,
                            input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi,
                             input int got);
    checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  function automatic logic [3:0] exp_ratio(input logic [1:0] w,
                                           input logic d, input logic s);
    return (w == 2'h0) ? (d ? 4'h2 : 4'h1) :
           (w == 2'h1) ? (d ? 4'h4 : (s ? 4'h2 : 4'h1)) :
           (d ? 4'h8 : (s ? 4'h4 : 4'h1));
  endfunction

  // Rotate-xor fold: one step per word at ratio 1, else r-1 steps
  function automatic logic [31:0] exp_fold(input logic [1:0] w, input int r,
                                           input int n);
    logic [31:0] s;
    logic [31:0] d;
    s = 32'h0;
    for (int i = 0; i < n; i++) begin
      d = host.word(i);
      d = (w == 2'h0) ? {24'h0, d[7:0]} :
          (w == 2'h1) ? {16'h0, d[15:0]} : d;
      for (int k = 0; k < ((r == 1) ? 1 : r - 1); k++) begin
        s = {s[30:0], s[31]} ^ d;
      end
    end
    return s;
  endfunction

  task automatic reconf(input logic [1:0] w, input logic d, input logic s,
                        input logic opt, input logic uen, input int n);
    int cnt;
    @(posedge MCLK);
    WIDTH_SEL <= w;
    DECOMP_EN <= d;
    SECURITY_EN <= s;
    INIT_DONE_OPT <= opt;
    USER_INIT_CLOCK_EN <= uen;
    IMAGE_WORDS <= 32'(n);
    repeat (4) @(posedge MCLK);
    cnt = 0;
    fork
      host.request(2100);
      while ((STATUS_N !== 1'b0 || CONF_DONE !== 1'b0) && cnt < 20) begin
        @(posedge MCLK);
        cnt++;
      end
    join
    check_range("request to low", 0, 12, cnt);
    check_bit("user mode cleared", 1'b0, USER_MODE);
    cnt = 0;
    while (STATUS_N !== 1'b1 && cnt < 100) begin
      @(posedge MCLK);
      cnt++;
    end
    check_range("status release", ST, STMAX, cnt);
    check_nib("ratio", exp_ratio(w, d, s), RATIO);
    check_bit("done low", 1'b0, CONF_DONE);
  endtask

  task automatic run_load(input logic [1:0] w, input logic d, input logic s,
                          input logic opt, input logic uen, input int n,
                          input int pause, input int lo, input int hi);
    int cnt;
    int r;
    reconf(w, d, s, opt, uen, n);
    r = int'(exp_ratio(w, d, s));
    host.load(0, n - 1, r, pause);
    repeat (10) @(posedge MCLK);
    check_bit("done before last word", 1'b0, CONF_DONE);
    host.load(n - 1, 1, r, pause);
    cnt = 0;
    while (CONF_DONE !== 1'b1 && cnt < 20) begin
      @(posedge MCLK);
      cnt++;
    end
    check_range("done after image", 0, 8, cnt);
    check_word("result", exp_fold(w, r, n), RESULT);
    check_bit("init pin enable", opt, INIT_DONE_OE);
    check_bit("init pin low", 1'b0, INIT_DONE);
    check_bit("not yet user", 1'b0, USER_MODE);
    cnt = 0;
    fork
      host.tail();
    join_none
    while (USER_MODE !== 1'b1 && cnt < 400) begin
      @(posedge MCLK);
      cnt++;
    end
    check_range("done to user mode", lo, hi, cnt);
    check_bit("status in user mode", 1'b1, STATUS_N);
    check_bit("done in user mode", 1'b1, CONF_DONE);
    check_bit("init pin level", opt, INIT_DONE);
  endtask

  initial begin
    int cnt;
    repeat (3) @(posedge MCLK);
    check_bit("reset status", 1'b0, STATUS_N);
    check_bit("reset done", 1'b0, CONF_DONE);
    check_bit("reset user", 1'b0, USER_MODE);
    check_bit("reset init enable", 1'b0, INIT_DONE_OE);
    RST_N <= 1'b1;
    cnt = 0;
    while (STATUS_N !== 1'b1 && cnt < 3000) begin
      @(posedge MCLK);
      cnt++;
    end
    check_range("power-on status", 2000, 2000 + STMAX, cnt);
    end_test("power_up");
    for (int i = 0; i < 16; i++) begin
      reconf(2'(i / 4), i[1], i[0], 1'b0, 1'b0, 1);
    end
    end_test("ratios");
    run_load(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 3, -1, UM, 40);
    end_test("load_osc_x8");
    run_load(2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 4, 2, 24, 120);
    end_test("load_user_clock_x32");
    run_load(2'h1, 1'b1, 1'b1, 1'b1, 1'b0, 1, 0, UM, 40);
    end_test("load_single_x16");
    stop_test();
  end
endmodule // testbench
